// file: design/iaj_decode_exec.sv
// Function
// - the memory increment is recognised by a fixed nine-bit prefix, the low seven bits naming the location.
// - the memory increment adds one to the nibble, writes it to accumulator and memory, and sets carry and zero.
// - bit-test jumps are five-bit prefixes over an eleven-bit target, testing accumulator bits 0 to 3 by a two-bit select.
// - a bit-test jump loads all eleven program counter bits when the bit is one, else the counter increments.
// - the carry jump loads the program counter from the target when carry is one, else it increments.
// - the absolute jump always replaces program counter bits ten to zero, whatever the flags or accumulator.
`timescale 1ns/100ps
`default_nettype none

module iaj_decode_exec #(
    // printed opcode is incomplete; set once confirmed
    parameter logic [4:0] CARRY_JUMP_PREFIX = iaj_pkg::CARRY_JUMP_PREFIX_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // instruction fetch
    input wire logic step,
    input wire logic [iaj_pkg::WORD_W-1:0] instr,
    output logic [iaj_pkg::PC_W-1:0] pc,
    // data memory
    output logic [iaj_pkg::RAM_ADDR_W-1:0] ram_addr,
    input wire logic [iaj_pkg::DATA_W-1:0] ram_rdata,
    output logic [iaj_pkg::DATA_W-1:0] ram_wdata,
    output logic ram_we,
    // core state
    output logic [iaj_pkg::DATA_W-1:0] acc,
    output logic carry_flag,
    output logic zero_flag,
    output logic unknown_op
);

    iaj_pkg::iaj_op_t op;
    logic [1:0] bit_sel;
    logic [iaj_pkg::PC_W-1:0] target;
    logic [4:0] prefix5;
    logic take_jump;
    logic [iaj_pkg::PC_W-1:0] next_pc;
    logic [iaj_pkg::DATA_W-1:0] inc_sum;
    logic inc_carry;
    logic inc_zero;
    logic exec;

    assign prefix5 = instr[iaj_pkg::WORD_W-1:iaj_pkg::JUMP_PREFIX_LSB];
    assign target = instr[iaj_pkg::PC_W-1:0];
    assign bit_sel = instr[iaj_pkg::BIT_JUMP_SEL_LSB+1:iaj_pkg::BIT_JUMP_SEL_LSB];

    always_comb
    begin
        op = iaj_pkg::OP_OTHER;
        if (instr[iaj_pkg::WORD_W-1:iaj_pkg::INC_PREFIX_LSB] == iaj_pkg::INC_PREFIX)
            op = iaj_pkg::OP_INC;
        else if ((prefix5 & iaj_pkg::BIT_JUMP_FIXED_MASK) == iaj_pkg::BIT_JUMP_FIXED_VALUE)
            op = iaj_pkg::OP_BIT_JUMP;
        else if (prefix5 == CARRY_JUMP_PREFIX)
            op = iaj_pkg::OP_CARRY_JUMP;
        else if (prefix5 == iaj_pkg::ABS_JUMP_PREFIX)
            op = iaj_pkg::OP_ABS_JUMP;
    end

    always_comb
    begin
        case (op)
            iaj_pkg::OP_BIT_JUMP: take_jump = acc[bit_sel];
            iaj_pkg::OP_CARRY_JUMP: take_jump = carry_flag;
            iaj_pkg::OP_ABS_JUMP: take_jump = 1'b1;
            default: take_jump = 1'b0;
        endcase
    end

    // instructions outside this group only advance the counter
    assign next_pc = take_jump ? target : pc + 11'h001;
    assign exec = step;
    assign unknown_op = step && (op == iaj_pkg::OP_OTHER);

    iaj_nibble_inc #(
        .WIDTH(iaj_pkg::DATA_W)
    ) u_inc (
        .operand(ram_rdata),
        .sum(inc_sum),
        .carry_out(inc_carry),
        .is_zero(inc_zero)
    );

    // write must land in the same cycle to keep one cycle per instruction
    assign ram_addr = instr[iaj_pkg::RAM_ADDR_W-1:0];
    assign ram_wdata = inc_sum;
    assign ram_we = exec && (op == iaj_pkg::OP_INC);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pc <= iaj_pkg::PC_RESET;
        else if (exec)
            pc <= next_pc;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            acc <= iaj_pkg::ACC_RESET;
            carry_flag <= iaj_pkg::CARRY_RESET;
            zero_flag <= iaj_pkg::ZERO_RESET;
        end
        else if (exec && op == iaj_pkg::OP_INC)
        begin
            acc <= inc_sum;
            carry_flag <= inc_carry;
            zero_flag <= inc_zero;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_inc_write_strobe: assert property (
        step && instr[15:7] == 9'h094 |-> ram_we && ram_addr == instr[6:0])
        else $error("memory increment did not write its location");

    chk_inc_acc_value: assert property (
        step && instr[15:7] == 9'h094 |=> acc == 4'($past(ram_rdata) + 4'h1))
        else $error("accumulator not loaded with incremented nibble");

    chk_inc_flags: assert property (
        step && instr[15:7] == 9'h094
        |=> carry_flag == ($past(ram_rdata) == 4'hf) && zero_flag == ($past(ram_rdata) == 4'hf))
        else $error("carry or zero wrong after increment");

    chk_bit0_jump: assert property (
        step && instr[15:11] == 5'h10 && acc[0] |=> pc == $past(instr[10:0]))
        else $error("bit 0 jump not taken");

    chk_bit3_jump: assert property (
        step && instr[15:11] == 5'h16 && acc[3] |=> pc == $past(instr[10:0]))
        else $error("bit 3 jump not taken");

    chk_bit_jump_fall: assert property (
        step && instr[15:14] == 2'b10 && !instr[11] && !acc[instr[13:12]]
        |=> pc == 11'($past(pc) + 11'h001))
        else $error("untaken bit jump did not increment");

    chk_carry_jump: assert property (
        step && instr[15:11] == CARRY_JUMP_PREFIX
        |=> pc == ($past(carry_flag) ? $past(instr[10:0]) : 11'($past(pc) + 11'h001)))
        else $error("carry jump went to the wrong place");

    chk_abs_jump: assert property (
        step && instr[15:11] == 5'h0e |=> pc == $past(instr[10:0]) && $stable(acc))
        else $error("absolute jump did not load the target");

    chk_one_cycle: assert property (
        !step |=> $stable(pc) && $stable(acc) && $stable(carry_flag))
        else $error("state moved without an instruction step");

    chk_bit1_jump: assert property (
        step && instr[15:11] == 5'h12 && acc[1] |=> pc == $past(instr[10:0]))
        else $error("bit 1 jump not taken");

    chk_bit2_jump: assert property (
        step && instr[15:11] == 5'h14 && acc[2] |=> pc == $past(instr[10:0]))
        else $error("bit 2 jump not taken");

    chk_inc_wdata: assert property (
        step && instr[15:7] == 9'h094 |-> ram_wdata == 4'(ram_rdata + 4'h1))
        else $error("memory increment wrote the wrong nibble");

    chk_write_only_inc: assert property (
        ram_we |-> step && instr[15:7] == 9'h094)
        else $error("memory written outside an increment");

    chk_jump_keeps_state: assert property (
        step && instr[15:14] == 2'b10 && !instr[11]
        |=> $stable(acc) && $stable(carry_flag) && $stable(zero_flag))
        else $error("bit jump disturbed accumulator or flags");

    chk_abs_keeps_flags: assert property (
        step && instr[15:11] == 5'h0e |=> $stable(carry_flag) && $stable(zero_flag))
        else $error("absolute jump disturbed the flags");

    chk_other_op_flag: assert property (
        step && instr[15:7] != 9'h094 && instr[15:11] != 5'h0e
        && instr[15:11] != CARRY_JUMP_PREFIX
        && !(instr[15:14] == 2'b10 && !instr[11]) |-> unknown_op && !ram_we)
        else $error("opcode outside the group not flagged");

    chk_other_op_advance: assert property (
        unknown_op |=> pc == 11'($past(pc) + 11'h001) && $stable(acc) && $stable(carry_flag))
        else $error("opcode outside the group changed more than the counter");

endmodule : iaj_decode_exec

`default_nettype wire

// file: shared/iaj_pkg.sv
`default_nettype none

package iaj_pkg;

    // widths of the core datapath
    localparam int WORD_W = 16;
    localparam int PC_W = 11;
    localparam int RAM_ADDR_W = 7;
    localparam int DATA_W = 4;

    // memory increment: nine-bit prefix above a seven-bit location
    localparam int INC_PREFIX_LSB = 7;
    localparam logic [8:0] INC_PREFIX = 9'h094;

    // five-bit jump prefixes above an eleven-bit target
    localparam int JUMP_PREFIX_LSB = 11;
    localparam logic [4:0] ABS_JUMP_PREFIX = 5'h0e;
    localparam logic [4:0] CARRY_JUMP_PREFIX_DEFAULT = 5'h1e;

    // bit-test jumps: 1 0 s1 s0 0, select field at bits 13:12
    localparam int BIT_JUMP_SEL_LSB = 12;
    localparam logic [4:0] BIT_JUMP_FIXED_MASK = 5'h19;
    localparam logic [4:0] BIT_JUMP_FIXED_VALUE = 5'h10;

    // reset values
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic ZERO_RESET = 1'b0;

    typedef enum logic [2:0]
    {
        OP_OTHER,
        OP_INC,
        OP_BIT_JUMP,
        OP_CARRY_JUMP,
        OP_ABS_JUMP
    } iaj_op_t;

endpackage : iaj_pkg

`default_nettype wire

// file: design/iaj_nibble_inc.sv
`timescale 1ns/100ps
`default_nettype none

module iaj_nibble_inc #(
    parameter int WIDTH = 4
) (
    // operand
    input wire logic [WIDTH-1:0] operand,
    // result and flags
    output logic [WIDTH-1:0] sum,
    output logic carry_out,
    output logic is_zero
);

    logic [WIDTH:0] wide_sum;

    assign wide_sum = {1'b0, operand} + {{WIDTH{1'b0}}, 1'b1};
    assign sum = wide_sum[WIDTH-1:0];
    assign carry_out = wide_sum[WIDTH];
    assign is_zero = (wide_sum[WIDTH-1:0] == {WIDTH{1'b0}});

endmodule : iaj_nibble_inc

`default_nettype wire

// file: test/iaj_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module iaj_ram_model (
    // clock
    input wire logic clock,
    // data port
    input wire logic [6:0] ram_addr,
    output logic [3:0] ram_rdata,
    input wire logic [3:0] ram_wdata,
    input wire logic ram_we
);
    logic [3:0] mem [128];
    // known pattern so the bench can mirror contents
    initial for (int i = 0; i < 128; i++) mem[i] = 4'(i);
    assign ram_rdata = mem[ram_addr];
    always @(posedge clock) if (ram_we) mem[ram_addr] <= ram_wdata;
endmodule : iaj_ram_model
`default_nettype wire

// file: test/increment_and_jump_decode_bench.sv
`timescale 1ns/100ps
`default_nettype none
module increment_and_jump_decode_bench;
    logic clock, nrst, step, ram_we, carry_flag, zero_flag, unknown_op, e_c, e_z;
    logic [15:0] instr, w;
    logic [10:0] pc, e_pc;
    logic [6:0] ram_addr;
    logic [3:0] ram_rdata, ram_wdata, acc, e_acc;
    logic [3:0] mir [128];
    logic [31:0] lfsr = 32'ha85046ab;
    int failures = 0, total_checks = 0;
    iaj_decode_exec dut (.clock(clock), .nrst(nrst), .step(step), .instr(instr), .pc(pc),
        .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_we(ram_we),
        .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag), .unknown_op(unknown_op));
    iaj_ram_model ram (.clock(clock), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .ram_wdata(ram_wdata), .ram_we(ram_we));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    // jump decision from the old acc and carry
    function automatic logic expect_jump(input logic [15:0] v, input logic [3:0] a, input logic c);
        logic bj;
        bj = v[15:14] == 2'b10 && !v[11];
        return v[15:11] == 5'h0e || (bj && a[v[13:12]])
            || (c && v[15:11] == iaj_pkg::CARRY_JUMP_PREFIX_DEFAULT);
    endfunction : expect_jump
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    // expectation mirrors ram and core state; bit jumps test the old acc
    task automatic run(input logic [15:0] v);
        logic inc, bj, cj, aj, tk;
        inc = v[15:7] == 9'h094;
        bj = v[15:14] == 2'b10 && !v[11];
        cj = v[15:11] == iaj_pkg::CARRY_JUMP_PREFIX_DEFAULT;
        aj = v[15:11] == 5'h0e;
        tk = expect_jump(v, e_acc, e_c);
        instr = v;
        step = 1'b1;
        #1;
        check(16'(ram_we), 16'(inc));
        check(16'(unknown_op), 16'(!(inc || bj || cj || aj)));
        check(16'(ram_addr), 16'(v[6:0]));
        if (inc)
        begin
            check(16'(ram_wdata), 16'(4'(mir[v[6:0]] + 4'h1)));
            e_c = mir[v[6:0]] == 4'hf;
            e_z = e_c;
            e_acc = mir[v[6:0]] + 4'h1;
            mir[v[6:0]] = e_acc;
        end
        e_pc = tk ? v[10:0] : e_pc + 11'h001;
        @(posedge clock);
        #1;
        check(16'(pc), 16'(e_pc));
        check(16'(acc), 16'(e_acc));
        check(16'({carry_flag, zero_flag}), 16'({e_c, e_z}));
    endtask : run
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #20000;
        failures++;
        print_verdict();
    end
    initial
    begin
        nrst = 1'b0;
        step = 1'b0;
        instr = 16'h0000;
        {e_pc, e_acc, e_c, e_z} = '0;
        for (int i = 0; i < 128; i++) mir[i] = 4'(i);
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        check(16'(pc), 16'h0000);
        check(16'({acc, carry_flag, zero_flag}), 16'h0000);
        // wrap from f sets both flags, then carry jump taken and not taken
        run(16'h4a0f);
        run(16'hf555);
        run(16'h4a01);
        run(16'hf123);
        run(16'h77ff);
        // idle cycle with an increment word on the bus: nothing may move
        step = 1'b0;
        instr = 16'h4a05;
        #1;
        check(16'(ram_we), 16'h0000);
        check(16'(unknown_op), 16'h0000);
        @(posedge clock);
        #1;
        check(16'(pc), 16'(e_pc));
        check(16'(acc), 16'(e_acc));
        // counter wraps from 7ff; location 5 must still hold its old nibble
        run(16'h4a05);
        repeat (300)
        begin
            lfsr = next_rand(lfsr);
            w = lfsr[15:0];
            case (lfsr[18:16])
                3'h0: w[15:7] = 9'h094;
                3'h1, 3'h5: w[15:11] = {2'b10, lfsr[20:19], 1'b0};
                3'h2: w[15:11] = 5'h1e;
                3'h3: w[15:11] = 5'h0e;
                default: ;
            endcase
            run(w);
        end
        step = 1'b0;
        print_verdict();
    end
endmodule : increment_and_jump_decode_bench
`default_nettype wire
